// >>> hdl/cfts_pkg.sv
// Register map, field positions and timing constants of the charger status block
package cfts_pkg;
  localparam logic [7:0] ADDR_FAULT_LO = 8'h20;
  localparam logic [7:0] ADDR_FAULT_HI = 8'h21;
  localparam logic [7:0] ADDR_THR_LO = 8'h22;
  localparam logic [7:0] ADDR_THR_HI = 8'h23;
  // Fault byte fields
  localparam int B_IN_OV = 7;
  localparam int B_BAT_OC = 6;
  localparam int B_IN_OC = 5;
  localparam int B_SYS_OV = 4;
  localparam int B_SYS_SHORT = 3;
  localparam int B_LATCHOFF = 2;
  localparam int B_BST_OV = 1;
  localparam int B_BST_UV = 0;
  localparam logic [7:0] FAULT_RDCLR_MASK = 8'he7;
  // Throttle high and low byte fields
  localparam int B_RSVD_ONE = 7;
  localparam int B_HOLD_EN = 6;
  localparam int B_WIDTH_LO = 4;
  localparam int B_PCLR = 3;
  localparam int B_PA_FAIL = 1;
  localparam int B_PA_EXIT = 0;
  localparam int B_VLIM = 7;
  localparam logic [7:0] THR_LO_RDCLR_MASK = 8'h7f;
  localparam logic [15:0] THR_RESET = 16'ha800;
  localparam logic [1:0] WIDTH_RESET = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_100US_NS = 100000;
  localparam int T_1MS_NS = 1000000;
  localparam int T_10MS_NS = 10000000;
  localparam int CYC_100US = T_100US_NS / CLK_PERIOD_NS;
  localparam logic [2:0] RETRY_LIMIT = 3'h7;
  typedef enum logic [1:0] {THR_IDLE, THR_PULSE, THR_HOLD} cfts_thr_state_t;
endpackage

// >>> hdl/cfts_status.sv
// Charger fault latches, throttle status register and throttle pulse shaper
// Notes on behaviour
// - Input OV, battery OC, input OC, latchoff, boost OV/UV latch; host read clears.
// - System OV sets bit 4 and keeps the converter off until the bit 4 latch is cleared.
// - Writing 0 to bit 4 or adapter removal clears system OV latch.
// - System short sets after seven failed restarts with rail below 2.4 V.
// - System short ignores reads; only a write of 0 clears it; resets to 0.
// - With hold enabled the throttle output stays low until pulse clear written 0.
// - Without hold, width code picks minimum low pulse 100 us, 1 ms, 10 ms.
// - Writing 0 to pulse clear in the hold state, after the minimum width, ends pulse, output goes high.
// - Peak-assist failure sets after seven consecutive load failures in that mode.
// - On failure peak-assist mode stops and stays off until failure and exit flags written 0.
// - Peak-assist mode ends on host disable or on any charger fault.
// - While peak-assist exit flag is set, throttle output held low until written 0.
// - Throttle bits 7..4 report 1 when fired; bit 7 host writable; reset 0.
// - Throttle bits 3..0 report 1 when fired; read only; reset 0.
`timescale 1ns/1ps
module cfts_status
  import cfts_pkg::*;
#(
  parameter int CYC_1MS = T_1MS_NS / CLK_PERIOD_NS,
  parameter int CYC_10MS = T_10MS_NS / CLK_PERIOD_NS
)(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic evt_input_overvoltage_i,
  input wire logic evt_battery_overcurrent_i,
  input wire logic evt_input_overcurrent_i,
  input wire logic evt_latchoff_i,
  input wire logic evt_boost_out_overvoltage_i,
  input wire logic evt_boost_out_undervoltage_i,
  input wire logic system_overvoltage_i,
  input wire logic adapter_removed_i,
  input wire logic system_rail_low_i,
  input wire logic restart_fail_i,
  input wire logic peak_assist_host_en_i,
  input wire logic input_bus_rail_load_fail_i,
  input wire logic input_bus_rail_load_ok_i,
  input wire logic [7:0] throttle_trig_i,
  output logic converter_en_o,
  output logic peak_assist_mode_o,
  output logic processor_throttle_n_o
);
  // Counter sized for the longest width, whichever override is largest
  localparam int CYC_LONG = (CYC_10MS > CYC_1MS) ? CYC_10MS : CYC_1MS;
  localparam int CW = $clog2(((CYC_LONG > CYC_100US) ? CYC_LONG : CYC_100US) + 1);

  logic [7:0] fault_r;
  logic [7:0] thr_lo_r;
  logic hold_en_r;
  logic [1:0] width_r;
  logic pclr_r;
  logic pa_fail_r;
  logic pa_exit_r;
  logic pa_mode_r;
  logic [2:0] short_cnt_r;
  logic [2:0] pa_cnt_r;
  logic [CW-1:0] pw_cnt_r;
  cfts_thr_state_t thr_st_r;
  logic [7:0] rdata_r;

  logic rd_flt, wr_flt, rd_tlo, wr_tlo, wr_thi;
  logic fault_any, short_set, pa_fail_set, pa_leave, pclr_wr0;
  logic [7:0] fault_set;
  logic [CW-1:0] pw_load;
  logic [7:0] thr_hi;

  assign rd_flt = reg_rd_i && (reg_addr_i == ADDR_FAULT_LO);
  assign wr_flt = reg_wr_i && (reg_addr_i == ADDR_FAULT_LO);
  assign rd_tlo = reg_rd_i && (reg_addr_i == ADDR_THR_LO);
  assign wr_tlo = reg_wr_i && (reg_addr_i == ADDR_THR_LO);
  assign wr_thi = reg_wr_i && (reg_addr_i == ADDR_THR_HI);

  assign fault_any = evt_input_overvoltage_i | evt_battery_overcurrent_i |
                     evt_input_overcurrent_i | evt_latchoff_i |
                     evt_boost_out_overvoltage_i | evt_boost_out_undervoltage_i |
                     system_overvoltage_i | short_set;
  assign short_set = restart_fail_i && system_rail_low_i &&
                     (short_cnt_r == RETRY_LIMIT - 3'h1);
  assign pa_fail_set = pa_mode_r && input_bus_rail_load_fail_i &&
                       (pa_cnt_r == RETRY_LIMIT - 3'h1);
  assign pa_leave = pa_mode_r && (!peak_assist_host_en_i || fault_any || pa_fail_set);

  always_comb
  begin
    fault_set = '0;
    fault_set[B_IN_OV] = evt_input_overvoltage_i;
    fault_set[B_BAT_OC] = evt_battery_overcurrent_i;
    fault_set[B_IN_OC] = evt_input_overcurrent_i;
    fault_set[B_SYS_OV] = system_overvoltage_i;
    fault_set[B_SYS_SHORT] = short_set;
    fault_set[B_LATCHOFF] = evt_latchoff_i;
    fault_set[B_BST_OV] = evt_boost_out_overvoltage_i;
    fault_set[B_BST_UV] = evt_boost_out_undervoltage_i;
  end

  // Set always wins over a read or write clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fault_r <= '0;
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (fault_set[i])
          fault_r[i] <= 1'b1;
        else if (rd_flt && FAULT_RDCLR_MASK[i])
          fault_r[i] <= 1'b0;
        else if (wr_flt && !FAULT_RDCLR_MASK[i] && !reg_wdata_i[i])
          fault_r[i] <= 1'b0;
      end
      if (adapter_removed_i && !system_overvoltage_i)
        fault_r[B_SYS_OV] <= 1'b0;
    end
  end

  // Converter stays off until the latch is cleared, not just the condition
  assign converter_en_o = !fault_r[B_SYS_OV];

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      short_cnt_r <= '0;
    else if (!system_rail_low_i || short_set)
      short_cnt_r <= '0;
    else if (restart_fail_i)
      short_cnt_r <= short_cnt_r + 3'h1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      thr_lo_r <= '0;
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (throttle_trig_i[i])
          thr_lo_r[i] <= 1'b1;
        else if (rd_tlo && THR_LO_RDCLR_MASK[i])
          thr_lo_r[i] <= 1'b0;
        else if (wr_tlo && i == B_VLIM && !reg_wdata_i[i])
          thr_lo_r[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hold_en_r <= THR_RESET[8 + B_HOLD_EN];
      width_r <= WIDTH_RESET;
    end
    else if (wr_thi)
    begin
      hold_en_r <= reg_wdata_i[B_HOLD_EN];
      width_r <= reg_wdata_i[B_WIDTH_LO +: 2];
    end
  end

  // Pulse clear reads back 0 for one cycle after a clearing write, then idles at 1
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pclr_r <= THR_RESET[8 + B_PCLR];
    else if (wr_thi)
      pclr_r <= reg_wdata_i[B_PCLR];
    else
      pclr_r <= 1'b1;
  end
  assign pclr_wr0 = wr_thi && !reg_wdata_i[B_PCLR];

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pa_fail_r <= 1'b0;
      pa_exit_r <= 1'b0;
    end
    else
    begin
      if (pa_fail_set)
        pa_fail_r <= 1'b1;
      else if (wr_thi && !reg_wdata_i[B_PA_FAIL])
        pa_fail_r <= 1'b0;
      if (pa_leave)
        pa_exit_r <= 1'b1;
      else if (wr_thi && !reg_wdata_i[B_PA_EXIT])
        pa_exit_r <= 1'b0;
    end
  end

  // Re-entry needs the host enable, and no latched failure
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pa_mode_r <= 1'b0;
    else if (pa_leave)
      pa_mode_r <= 1'b0;
    else if (peak_assist_host_en_i && !pa_fail_r && !pa_exit_r && !fault_any)
      pa_mode_r <= 1'b1;
  end
  assign peak_assist_mode_o = pa_mode_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pa_cnt_r <= '0;
    else if (!pa_mode_r || input_bus_rail_load_ok_i || pa_fail_set)
      pa_cnt_r <= '0;
    else if (input_bus_rail_load_fail_i)
      pa_cnt_r <= pa_cnt_r + 3'h1;
  end

  // Code 3 is undefined; treated as code 2, the 10 ms width
  always_comb
  begin
    case (width_r)
      2'h0: pw_load = CW'(CYC_100US - 1);
      2'h1: pw_load = CW'(CYC_1MS - 1);
      default: pw_load = CW'(CYC_10MS - 1);
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      thr_st_r <= THR_IDLE;
      pw_cnt_r <= '0;
    end
    else
    begin
      case (thr_st_r)
        THR_IDLE:
          if (|throttle_trig_i)
          begin
            thr_st_r <= THR_PULSE;
            pw_cnt_r <= pw_load;
          end
        THR_PULSE:
          if (|throttle_trig_i)
            pw_cnt_r <= pw_load;
          else if (pw_cnt_r != '0)
            pw_cnt_r <= pw_cnt_r - CW'(1);
          else if (hold_en_r && !pclr_wr0)
            thr_st_r <= THR_HOLD;
          else
            thr_st_r <= THR_IDLE;
        THR_HOLD:
          if (pclr_wr0)
            thr_st_r <= THR_IDLE;
        default:
          thr_st_r <= THR_IDLE;
      endcase
    end
  end

  assign processor_throttle_n_o = (thr_st_r == THR_IDLE) && !pa_exit_r;

  always_comb
  begin
    thr_hi = '0;
    thr_hi[B_RSVD_ONE] = THR_RESET[8 + B_RSVD_ONE];
    thr_hi[B_HOLD_EN] = hold_en_r;
    thr_hi[B_WIDTH_LO +: 2] = width_r;
    thr_hi[B_PCLR] = pclr_r;
    thr_hi[B_PA_FAIL] = pa_fail_r;
    thr_hi[B_PA_EXIT] = pa_exit_r;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_r <= '0;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        ADDR_FAULT_LO: rdata_r <= fault_r;
        ADDR_THR_LO: rdata_r <= thr_lo_r;
        ADDR_THR_HI: rdata_r <= thr_hi;
        default: rdata_r <= '0;
      endcase
    end
  end
  assign reg_rdata_o = rdata_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_READ_CLEARS: assert property (rd_flt && !evt_input_overvoltage_i |=> !fault_r[B_IN_OV])
    else $error("input OV flag survived a read");
  AST_SYSOV_CONV: assert property (system_overvoltage_i |=> !converter_en_o)
    else $error("converter enabled during system OV");
  AST_SYSOV_WR0: assert property (wr_flt && !reg_wdata_i[B_SYS_OV] && !system_overvoltage_i
                                  |=> converter_en_o)
    else $error("system OV not cleared by write 0");
  AST_SHORT_SEVEN: assert property (short_set |-> short_cnt_r == 3'h6)
    else $error("system short set at wrong count");
  AST_SHORT_KEEP: assert property (fault_r[B_SYS_SHORT] && !wr_flt |=> fault_r[B_SYS_SHORT])
    else $error("system short lost without write");
  AST_HOLD_LOW: assert property (thr_st_r == THR_HOLD && !pclr_wr0 |=> !processor_throttle_n_o)
    else $error("throttle released during hold");
  AST_PULSE_MIN: assert property ($fell(processor_throttle_n_o) && width_r == 2'h0 && !pa_exit_r
                                  |-> !processor_throttle_n_o [*8])
    else $error("throttle pulse too short");
  AST_CLEAR_END: assert property (thr_st_r == THR_HOLD && pclr_wr0 && !pa_exit_r
                                  && !pa_leave |=> processor_throttle_n_o)
    else $error("pulse clear did not release throttle");
  AST_PA_FAIL_OFF: assert property (pa_fail_set |=> pa_fail_r && !pa_mode_r)
    else $error("peak-assist failure not handled");
  AST_PA_LEAVE: assert property (pa_mode_r && fault_any |=> !pa_mode_r ##0 pa_exit_r)
    else $error("peak-assist kept on fault");
  AST_EXIT_LOW: assert property (pa_exit_r |-> !processor_throttle_n_o)
    else $error("throttle high with exit flag");
  AST_TRIG_SET: assert property (throttle_trig_i[3] |=> thr_lo_r[3])
    else $error("throttle status bit not set");
  AST_SET_WINS: assert property (rd_flt && evt_input_overvoltage_i |=> fault_r[B_IN_OV])
    else $error("fault lost on clearing read");
  AST_WR1_IGN: assert property (wr_flt && fault_r[B_BAT_OC] |=> fault_r[B_BAT_OC])
    else $error("read-only fault cleared by write");

  COV_HOLD: cover property (thr_st_r == THR_HOLD ##1 thr_st_r == THR_IDLE);
  COV_PA_FAIL: cover property (pa_fail_set);
  COV_SHORT: cover property (short_set);
  COV_SYSOV: cover property (system_overvoltage_i ##1 !system_overvoltage_i ##[1:5] converter_en_o);
endmodule // cfts_status

// >>> sim/cfts_host_model.sv
// Host model issuing byte register reads and writes to the status block
`timescale 1ns/1ps
module cfts_host_model
(
  input wire logic clk_i,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  initial
  begin
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_addr_o = 8'hff;
    reg_wdata_o = 8'hff;
  end
  // Idle bus shows the inverse, so a stale address never looks live
  task automatic read_byte(input logic [7:0] a);
    @(posedge clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
  endtask
  // Clearing writes carry 0 in the flag position
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
endmodule // cfts_host_model

// >>> sim/test_charger_fault_throttle_status.sv
// Self-checking bench for the charger fault and throttle status block
`timescale 1ns/1ps
module test_charger_fault_throttle_status;
  import cfts_pkg::*;
  localparam int C1 = 20;
  localparam int C10 = 40;
  typedef struct {logic [7:0] e; logic [7:0] m;} cfts_note_t;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [5:0] ev = '0;
  logic sov = 0, arm = 0, rlow = 0, rfail = 0, pa_en = 0, lfail = 0, lok = 0;
  logic [7:0] trig = '0;
  logic rd, wr, cen, pam, thr_n;
  logic [7:0] addr, wdata, rdata;
  logic rd_seen = 0;
  cfts_note_t notes[$];
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int fpos[6] = '{0, 1, 2, 5, 6, 7};
  initial forever #50 ref_clk_i = ~ref_clk_i;
  cfts_host_model i_cfts_host_model(.clk_i(ref_clk_i), .reg_rd_o(rd), .reg_wr_o(wr),
    .reg_addr_o(addr), .reg_wdata_o(wdata));
  cfts_status #(.CYC_1MS(C1), .CYC_10MS(C10)) i_cfts_status(.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .evt_input_overvoltage_i(ev[5]),
    .evt_battery_overcurrent_i(ev[4]), .evt_input_overcurrent_i(ev[3]),
    .evt_latchoff_i(ev[2]), .evt_boost_out_overvoltage_i(ev[1]),
    .evt_boost_out_undervoltage_i(ev[0]), .system_overvoltage_i(sov),
    .adapter_removed_i(arm), .system_rail_low_i(rlow), .restart_fail_i(rfail),
    .peak_assist_host_en_i(pa_en), .input_bus_rail_load_fail_i(lfail),
    .input_bus_rail_load_ok_i(lok), .throttle_trig_i(trig), .converter_en_o(cen),
    .peak_assist_mode_o(pam), .processor_throttle_n_o(thr_n));
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rx(logic [7:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
    notes.push_back('{e, m});
    i_cfts_host_model.read_byte(a);
  endtask
  task automatic wx(logic [7:0] a, logic [7:0] d);
    i_cfts_host_model.write_byte(a, d);
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wait_hi(int lim);
    for (int n = 0; n < lim && thr_n !== 1'b1; n++)
      tick(1);
  endtask
  task automatic thr_width(logic [1:0] c, int e);
    int n;
    n = 0;
    wx(ADDR_THR_HI, {2'h0, c, 4'h8});
    @(posedge ref_clk_i);
    trig <= 8'h10;
    @(posedge ref_clk_i);
    trig <= 8'h00;
    #1;
    while (thr_n === 1'b0 && n < 2000)
    begin
      tick(1);
      n++;
    end
    check("low cycles", n, e);
  endtask
  // Read data lands one cycle after the strobe edge
  always @(posedge ref_clk_i)
    rd_seen <= rd;
  always @(negedge ref_clk_i)
  begin
    cfts_note_t n;
    if (rd_seen)
    begin
      if (notes.size() == 0)
        check("read note", 1, 0);
      else
      begin
        n = notes.pop_front();
        check("read data", rdata & n.m, n.e & n.m);
      end
    end
  end
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      complete_run();
    end
  end
  initial
  begin
    logic [7:0] r;
    void'($urandom(32'hd81f));
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rx(ADDR_FAULT_LO, 8'h00);
    rx(ADDR_FAULT_HI, 8'h00);
    rx(ADDR_THR_LO, 8'h00);
    rx(ADDR_THR_HI, 8'ha8);
    rx(8'h30, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge ref_clk_i) ev[i] <= 1'b1;
      @(posedge ref_clk_i) ev[i] <= 1'b0;
      wx(ADDR_FAULT_LO, 8'h00);
      rx(ADDR_FAULT_LO, 8'h01 << fpos[i]);
      rx(ADDR_FAULT_LO, 8'h00);
    end
    fork
      rx(ADDR_FAULT_LO, 8'h00);
      begin
        @(posedge ref_clk_i) ev[5] <= 1'b1;
        @(posedge ref_clk_i) ev[5] <= 1'b0;
      end
    join
    rx(ADDR_FAULT_LO, 8'h80);
    @(posedge ref_clk_i) sov <= 1'b1;
    tick(2);
    check("conv en", cen, 0);
    rx(ADDR_FAULT_LO, 8'h10);
    wx(ADDR_FAULT_LO, 8'h00);
    rx(ADDR_FAULT_LO, 8'h10);
    @(posedge ref_clk_i) sov <= 1'b0;
    wx(ADDR_FAULT_LO, 8'hff);
    tick(2);
    check("conv en", cen, 0);
    wx(ADDR_FAULT_LO, 8'h00);
    tick(1);
    check("conv en", cen, 1);
    @(posedge ref_clk_i) sov <= 1'b1;
    @(posedge ref_clk_i) sov <= 1'b0;
    @(posedge ref_clk_i) arm <= 1'b1;
    @(posedge ref_clk_i) arm <= 1'b0;
    rx(ADDR_FAULT_LO, 8'h00);
    rlow <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      if (i == 6)
        rx(ADDR_FAULT_LO, 8'h00);
      @(posedge ref_clk_i) rfail <= 1'b1;
      @(posedge ref_clk_i) rfail <= 1'b0;
    end
    rx(ADDR_FAULT_LO, 8'h08);
    rx(ADDR_FAULT_LO, 8'h08);
    wx(ADDR_FAULT_LO, 8'h00);
    rlow <= 1'b0;
    rx(ADDR_FAULT_LO, 8'h00);
    thr_width(2'h0, CYC_100US);
    thr_width(2'h1, C1);
    thr_width(2'h2, C10);
    thr_width(2'h3, C10);
    rx(ADDR_THR_LO, 8'h10);
    r = 8'($urandom_range(1, 255));
    @(posedge ref_clk_i) trig <= r;
    @(posedge ref_clk_i) trig <= 8'h00;
    rx(ADDR_THR_LO, r);
    wx(ADDR_THR_LO, 8'hff);
    rx(ADDR_THR_LO, r & 8'h80);
    wx(ADDR_THR_LO, 8'h00);
    rx(ADDR_THR_LO, 8'h00);
    wait_hi(C10 + 5);
    wx(ADDR_THR_HI, 8'h68);
    rx(ADDR_THR_HI, 8'he8);
    @(posedge ref_clk_i) trig <= 8'h01;
    @(posedge ref_clk_i) trig <= 8'h00;
    tick(C10 + 20);
    check("throttle hold", thr_n, 0);
    wx(ADDR_THR_HI, 8'h60);
    tick(2);
    check("throttle clear", thr_n, 1);
    wx(ADDR_THR_HI, 8'h28);
    rx(ADDR_THR_LO, 8'h01, 8'h7f);
    @(posedge ref_clk_i) pa_en <= 1'b1;
    tick(3);
    check("pa mode", pam, 1);
    for (int i = 0; i < 7; i++)
    begin
      if (i == 6)
        check("pa mode", pam, 1);
      @(posedge ref_clk_i) lfail <= 1'b1;
      @(posedge ref_clk_i) lfail <= 1'b0;
    end
    tick(2);
    check("pa mode", pam, 0);
    rx(ADDR_THR_HI, 8'h02, 8'h02);
    wx(ADDR_THR_HI, 8'h28);
    tick(3);
    check("pa mode", pam, 1);
    wait_hi(C10 + 5);
    @(posedge ref_clk_i) pa_en <= 1'b0;
    tick(2);
    check("pa mode", pam, 0);
    tick(C10 + 10);
    check("exit hold", thr_n, 0);
    rx(ADDR_THR_HI, 8'h01, 8'h01);
    wx(ADDR_THR_HI, 8'h28);
    wait_hi(C10 + 5);
    check("exit clear", thr_n, 1);
    @(posedge ref_clk_i) pa_en <= 1'b1;
    tick(3);
    @(posedge ref_clk_i) lok <= 1'b1;
    @(posedge ref_clk_i) ev[3] <= 1'b1;
    lok <= 1'b0;
    @(posedge ref_clk_i) ev[3] <= 1'b0;
    tick(2);
    check("pa mode", pam, 0);
    rx(ADDR_FAULT_LO, 8'h20);
    tick(5);
    complete_run();
  end
endmodule // test_charger_fault_throttle_status
